// *** design/lpcal_map.vh ***
/*
 Constants for the low-power oscillator calibration block: register
 byte addresses, field positions, reset values, state codes and the
 timing figures of a calibration run.
 Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
*/
// Summary of operation
// - 9-bit reference counter on accurate source
// - 10-bit low-power counter, direct or divide-by-4
// - Only low four trim bits are writable
// - Larger trim lowers oscillator frequency
// - Reference count 0x1FF stops both counters
// - Control bit 4 selects crystal reference
// - Control bit 3 resets counters, disables logic
// - Bits 2 and 1 clear the counters
// - Bit 0 starts a run, clearing aborts
// - Status bits 3-2 give calibration state
// - Status bit 0 high while run active
// - Run lasts about 4 ms or 16 ms
// - Trim resets to 0x08, others to zero
`ifndef LPCAL_MAP_VH
`define LPCAL_MAP_VH

`define LPCAL_ADDR_TRIM    32'hffff042c
`define LPCAL_ADDR_CTRL    32'hffff0440
`define LPCAL_ADDR_STAT    32'hffff0444
`define LPCAL_ADDR_REFCNT  32'hffff0448
`define LPCAL_ADDR_LPCNT   32'hffff044c

`define LPCAL_TRIM_W       4
`define LPCAL_TRIM_RST     4'h8
`define LPCAL_CTRL_W       5
`define LPCAL_CTRL_RST     5'h00
`define LPCAL_CTRL_EN      0
`define LPCAL_CTRL_CLR_REF 1
`define LPCAL_CTRL_CLR_LP  2
`define LPCAL_CTRL_CALRST  3
`define LPCAL_CTRL_XTAL    4

`define LPCAL_STAT_BUSY    0
`define LPCAL_STAT_EN      1
`define LPCAL_STAT_ST_LO   2
`define LPCAL_STAT_ST_HI   3

`define LPCAL_REF_W        9
`define LPCAL_LP_W         10
`define LPCAL_REF_TERM     9'h1ff
`define LPCAL_LP_MAX       10'h3ff
`define LPCAL_DIV_LAST     2'h3

`define LPCAL_ST_IDLE      2'h0
`define LPCAL_ST_CNTEN     2'h1
`define LPCAL_ST_COUNT     2'h2
`define LPCAL_ST_DONE      2'h3

`define LPCAL_CLK_MHZ      10
`define LPCAL_RUN_PREC_US  4000
`define LPCAL_RUN_XTAL_US  16000
`define LPCAL_TMO_FACTOR   2
`define LPCAL_TMO_W        20

`define LPCAL_HTRANS_ACT   1
`define LPCAL_HSIZE_WORD   3'h2

`endif

// *** design/lpcal_edge.v ***
/*
 Input synchroniser and rising-edge detector for the oscillator pins.
 Each channel passes two flip-flops before a third one is compared
 for the edge. Assumes every input is slow against clk.
*/
`default_nettype none

module lpcal_edge #(
  parameter CHANNELS = 3
) (
  // Clock and reset
  input  wire                clk,
  input  wire                sys_rst,
  // Asynchronous oscillator levels
  input  wire [CHANNELS-1:0] osc_in,
  // One-cycle pulse per rising edge
  output wire [CHANNELS-1:0] rise
);

  reg [CHANNELS-1:0] meta_r;
  reg [CHANNELS-1:0] sync_r;
  reg [CHANNELS-1:0] last_r;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
      // The first stage feeds only the second to keep metastability contained.
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          last_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= osc_in[g];
          sync_r[g] <= meta_r[g];
          last_r[g] <= sync_r[g];
        end
      end
      assign rise[g] = sync_r[g] & ~last_r[g];
    end
  endgenerate

endmodule

`default_nettype wire

// *** design/lpcal_top.v ***
/*
 Low-power oscillator calibration block: trim, control and status
 registers, a 9-bit reference counter and a 10-bit low-power counter,
 all reached over an AHB-Lite slave port.
 Assumes the oscillators arrive as plain levels far slower than the
 10 MHz clk, and that the trim code drives the oscillator directly.
*/
`include "lpcal_map.vh"
`default_nettype none

module lpcal_top #(
  parameter REF_W        = `LPCAL_REF_W,
  parameter LP_W         = `LPCAL_LP_W,
  parameter TMO_PREC_CYC = `LPCAL_RUN_PREC_US * `LPCAL_CLK_MHZ * `LPCAL_TMO_FACTOR,
  parameter TMO_XTAL_CYC = `LPCAL_RUN_XTAL_US * `LPCAL_CLK_MHZ * `LPCAL_TMO_FACTOR
) (
  // Clock and reset
  input  wire                      clk,
  input  wire                      sys_rst,

  // AHB-Lite slave
  input  wire                      hsel,
  input  wire [31:0]               haddr,
  input  wire [1:0]                htrans,
  input  wire                      hwrite,
  input  wire [2:0]                hsize,
  input  wire [31:0]               hwdata,
  input  wire                      hready,
  output reg                       hreadyout,
  output reg                       hresp,
  output reg  [31:0]               hrdata,

  // Oscillator inputs
  input  wire                      osc_prec_in,
  input  wire                      osc_xtal_in,
  input  wire                      osc_lp_in,

  // Trim code to the low-power oscillator
  output reg  [`LPCAL_TRIM_W-1:0]  lp_trim_code
);

  localparam [1:0] ST_IDLE  = `LPCAL_ST_IDLE;
  localparam [1:0] ST_CNTEN = `LPCAL_ST_CNTEN;
  localparam [1:0] ST_COUNT = `LPCAL_ST_COUNT;
  localparam [1:0] ST_DONE  = `LPCAL_ST_DONE;

  localparam [`LPCAL_TMO_W-1:0] TMO_PREC = TMO_PREC_CYC[`LPCAL_TMO_W-1:0];
  localparam [`LPCAL_TMO_W-1:0] TMO_XTAL = TMO_XTAL_CYC[`LPCAL_TMO_W-1:0];

  // Register file
  reg  [`LPCAL_CTRL_W-1:0]   ctrl_r;
  reg  [1:0]                 state_r;
  reg  [1:0]                 state_nxt;
  reg                        done_hold_r;
  reg  [REF_W-1:0]           ref_cnt_r;
  reg  [LP_W-1:0]            lp_cnt_r;
  reg  [1:0]                 div_r;
  reg  [`LPCAL_TMO_W-1:0]    tmo_r;

  // Bus phase tracking
  reg                        wr_pend_r;
  reg  [31:0]                wr_addr_r;
  reg                        rd_pend_r;
  reg  [31:0]                rd_addr_r;
  reg  [31:0]                rd_nxt;

  wire [2:0]                 osc_rise;
  wire                       ctl_en;
  wire                       ctl_calrst;
  wire                       ctl_xtal;
  wire                       ref_tick;
  wire                       lp_raw_tick;
  wire                       lp_tick;
  wire                       counting;
  wire                       ref_term;
  wire                       tmo_hit;
  wire                       addr_ph;
  wire                       busy;

  // Synchronise the three oscillator pins and find their rising edges.
  lpcal_edge #(
    .CHANNELS (3)
  ) u_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .osc_in  ({osc_lp_in, osc_xtal_in, osc_prec_in}),
    .rise    (osc_rise)
  );

  assign ctl_en     = ctrl_r[`LPCAL_CTRL_EN];
  assign ctl_calrst = ctrl_r[`LPCAL_CTRL_CALRST];
  assign ctl_xtal   = ctrl_r[`LPCAL_CTRL_XTAL];

  // Reference pulse comes from the crystal or the precision oscillator.
  assign ref_tick = ctl_xtal ? osc_rise[1] : osc_rise[0];

  // The low-power pulse is divided by four whenever the crystal is the
  // reference, so both counters see the same nominal rate.
  assign lp_raw_tick = osc_rise[2];
  assign lp_tick = ctl_xtal ? (lp_raw_tick & (div_r == `LPCAL_DIV_LAST))
                            : lp_raw_tick;

  assign ref_term = (ref_cnt_r == `LPCAL_REF_TERM);
  assign counting = (state_r == ST_COUNT) && !ref_term;
  assign tmo_hit  = (tmo_r == (ctl_xtal ? TMO_XTAL : TMO_PREC));
  assign busy     = (state_r == ST_CNTEN) || (state_r == ST_COUNT);
  assign addr_ph  = hsel && htrans[`LPCAL_HTRANS_ACT] && hready
                    && (hsize == `LPCAL_HSIZE_WORD);

  // Calibration sequencer.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (ctl_en && !ctl_calrst && !done_hold_r) begin
          state_nxt = ST_CNTEN;
        end
      end
      ST_CNTEN: begin
        if (!ctl_en || ctl_calrst) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!ctl_en || ctl_calrst) begin
          state_nxt = ST_IDLE;
        end else if (ref_term) begin
          state_nxt = ST_DONE;
        end else if (tmo_hit) begin
          // A dead reference oscillator would otherwise hang the run.
          state_nxt = ST_IDLE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // A finished run is not restarted until software clears the enable bit or sets CALRST,
  // so the frozen counts stay put while the enable bit remains set and CALRST and both counter clear bits stay clear.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_hold_r <= 1'b0;
    end else if (!ctl_en || ctl_calrst) begin
      done_hold_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      done_hold_r <= 1'b1;
    end
  end

  // Run-length watchdog, measured in system clocks.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmo_r <= {`LPCAL_TMO_W{1'b0}};
    end else if (state_r != ST_COUNT) begin
      tmo_r <= {`LPCAL_TMO_W{1'b0}};
    end else if (!tmo_hit) begin
      tmo_r <= tmo_r + 1'b1;
    end
  end

  // Divide-by-four prescaler for the low-power oscillator.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 2'h0;
    end else if (state_r == ST_CNTEN || ctl_calrst) begin
      div_r <= 2'h0;
    end else if (counting && lp_raw_tick) begin
      div_r <= div_r + 2'h1;
    end
  end

  // Reference counter: cleared at run start or on command, frozen at
  // terminal count.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_r <= {REF_W{1'b0}};
    end else if (ctl_calrst || ctrl_r[`LPCAL_CTRL_CLR_REF]
                 || state_r == ST_CNTEN) begin
      ref_cnt_r <= {REF_W{1'b0}};
    end else if (counting && ref_tick) begin
      ref_cnt_r <= ref_cnt_r + 1'b1;
    end
  end

  // Low-power counter: saturates rather than wraps, so a badly fast
  // oscillator still reads as the larger count.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lp_cnt_r <= {LP_W{1'b0}};
    end else if (ctl_calrst || ctrl_r[`LPCAL_CTRL_CLR_LP]
                 || state_r == ST_CNTEN) begin
      lp_cnt_r <= {LP_W{1'b0}};
    end else if (counting && lp_tick && lp_cnt_r != {LP_W{1'b1}}) begin
      lp_cnt_r <= lp_cnt_r + 1'b1;
    end
  end

  // Bus address phase capture and read wait state.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h00000000;
      rd_pend_r <= 1'b0;
      rd_addr_r <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp     <= 1'b0;
      wr_pend_r <= addr_ph && hwrite;
      if (addr_ph) begin
        wr_addr_r <= haddr;
        rd_addr_r <= haddr;
      end
      // Reads take one wait state so a write just before is seen.
      if (addr_ph && !hwrite) begin
        rd_pend_r <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // Register writes in the data phase.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lp_trim_code <= `LPCAL_TRIM_RST;
      ctrl_r       <= `LPCAL_CTRL_RST;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `LPCAL_ADDR_TRIM: begin
          // A higher code slows the oscillator.
          lp_trim_code <= hwdata[`LPCAL_TRIM_W-1:0];
        end
        `LPCAL_ADDR_CTRL: begin
          ctrl_r <= hwdata[`LPCAL_CTRL_W-1:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // Read multiplexer; reserved and unmapped bits read as zero.
  always @* begin
    rd_nxt = 32'h00000000;
    case (rd_addr_r)
      `LPCAL_ADDR_TRIM: begin
        rd_nxt[`LPCAL_TRIM_W-1:0] = lp_trim_code;
      end
      `LPCAL_ADDR_CTRL: begin
        rd_nxt[`LPCAL_CTRL_W-1:0] = ctrl_r;
      end
      `LPCAL_ADDR_STAT: begin
        rd_nxt[`LPCAL_STAT_BUSY] = busy;
        rd_nxt[`LPCAL_STAT_EN]   = ctl_en;
        rd_nxt[`LPCAL_STAT_ST_HI:`LPCAL_STAT_ST_LO] = state_r;
      end
      `LPCAL_ADDR_REFCNT: begin
        rd_nxt[REF_W-1:0] = ref_cnt_r;
      end
      `LPCAL_ADDR_LPCNT: begin
        rd_nxt[LP_W-1:0] = lp_cnt_r;
      end
      default: begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_r) begin
      hrdata <= rd_nxt;
    end
  end

endmodule

`default_nettype wire

// *** verification/lpcal_top_props.sv ***
/*
 Checker for the calibration block: bus timing, trim port and read widths.
 Assumes the register map header and one clock domain on clk.
*/
`include "lpcal_map.vh"
`default_nettype none
module lpcal_props #(
  parameter REF_W = 9,
  parameter LP_W  = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Trim output
  input wire logic [3:0]  lp_trim_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_acc(w);
    hsel && htrans[1] && hready && hsize == 3'h2 && hwrite == w;
  endsequence
  sequence s_done;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_one_wait: assert property (s_acc(1'b0) |=> s_done)
    else $error("read wait is not one cycle");
  a_write_no_wait: assert property (s_acc(1'b1) |=> hreadyout)
    else $error("write was stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_trim_reset: assert property ($past(sys_rst) |-> lp_trim_code == 4'h8)
    else $error("trim not at reset value");
  a_trim_write: assert property (s_acc(1'b1) ##0 haddr == `LPCAL_ADDR_TRIM
    |=> ##1 lp_trim_code == $past(hwdata[3:0])) else $error("trim write lost");
  a_trim_read: assert property (s_acc(1'b0) ##0 haddr == `LPCAL_ADDR_TRIM
    |=> s_done ##0 hrdata == {28'h0, lp_trim_code}) else $error("trim read wrong");
  a_ref_width: assert property (s_acc(1'b0) ##0 haddr == `LPCAL_ADDR_REFCNT
    |=> s_done ##0 hrdata[31:REF_W] == 0) else $error("ref count too wide");
  a_lp_width: assert property (s_acc(1'b0) ##0 haddr == `LPCAL_ADDR_LPCNT
    |=> s_done ##0 hrdata[31:LP_W] == 0) else $error("lp count too wide");
  a_status_busy: assert property (s_acc(1'b0) ##0 haddr == `LPCAL_ADDR_STAT
    |=> s_done ##0 (hrdata[0] == (hrdata[3] ^ hrdata[2]) && hrdata[31:4] == 0))
    else $error("busy bit disagrees with state");
endmodule
bind lpcal_top lpcal_props #(.REF_W(REF_W), .LP_W(LP_W)) u_props (.clk(clk),
  .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .lp_trim_code(lp_trim_code));
`default_nettype wire

// *** verification/tb_lp_osc_calibration_counters.sv ***
/*
 Bench for the calibration block: reset values, trim, runs and aborts.
 Assumes oscillators scaled down to a few clk periods to keep runs short.
*/
`include "lpcal_map.vh"
`default_nettype none
module tb_lp_osc_calibration_counters;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] TR = `LPCAL_ADDR_TRIM;
  localparam logic [31:0] CT = `LPCAL_ADDR_CTRL;
  localparam logic [31:0] ST = `LPCAL_ADDR_STAT;
  localparam logic [31:0] RC = `LPCAL_ADDR_REFCNT;
  localparam logic [31:0] LC = `LPCAL_ADDR_LPCNT;
  logic        clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, rdy_n = 1;
  logic        hreadyout, hresp, osc_p = 0, osc_x = 0, osc_l = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rd_n, v;
  logic [31:0] seed = 32'hb4937f59;
  logic [1:0]  htrans = 0;
  logic [3:0]  trim, tm;
  logic [31:0] ra [5] = '{CT, ST, RC, LC, 32'hffff0450};
  int          err_count = 0, checks_done = 0, cyc = 0, t0;
  int          pp = 8, xp = 24, lp = 6;
  lpcal_top #(.TMO_PREC_CYC(8000), .TMO_XTAL_CYC(30000)) uut (.clk(clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .osc_prec_in(osc_p), .osc_xtal_in(osc_x),
    .osc_lp_in(osc_l), .lp_trim_code(trim));
  initial forever #50 clk = ~clk;
  // Oscillators toggle off the clk edges; low-power runs at 4/3 the precision rate and 4 times the crystal rate.
  initial #17 forever #(pp * 50) osc_p = ~osc_p;
  initial #17 forever #(xp * 50) osc_x = ~osc_x;
  initial #33 forever #(lp * 50) osc_l = ~osc_l;
  // Values before the edge are what the edge itself samples.
  always @(negedge clk) begin
    rdy_n <= hreadyout;
    rd_n <= hrdata;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (!rdy_n);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    do @(posedge clk); while (!rdy_n);
    rd = rd_n;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic near(input logic [31:0] g, input int e, tol, input string m);
    checks_done++;
    if ($isunknown(g) || g + tol < e || g > e + tol) begin
      err_count++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, m, g, e);
    end
  endtask
  task automatic rdc(input logic [31:0] a, e, input string m);
    bus(0, a, 0);
    chk(rd, e, m);
  endtask
  task automatic run(input logic [31:0] c);
    int per;
    per = c[4] ? xp : pp;
    bus(1, CT, c);
    bus(1, CT, c | 1);
    t0 = cyc;
    rdc(ST, 32'hb, "status in run");
    // Poll past the one-cycle finished state so idle is what gets checked.
    for (int i = 0; i < 9000 && (rd[0] !== 1'b0 || rd[3:2] !== 2'h0); i++) bus(0, ST, 0);
    near(cyc - t0, 511 * per, per + 16, "run length");
    chk(rd, 32'h2, "status after run");
    rdc(RC, 32'h1ff, "ref count");
    bus(0, LC, 0);
    near(rd, c[4] ? 511 * per / lp / 4 : 511 * per / lp, 3, "lp count");
    $display("run %h done", c);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(60000 * 100);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    rdc(TR, 32'h8, "trim reset");
    foreach (ra[i]) rdc(ra[i], 0, "reset");
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      tm = i == 0 ? 4'h0 : i == 1 ? 4'hf : seed[3:0];
      seed = lfsr(seed);
      bus(1, TR, {28'h0, tm});
      rdc(TR, {28'h0, tm}, "trim");
      chk({28'h0, trim}, {28'h0, tm}, "trim port");
    end
    $display("trim test done");
    run(0);
    bus(0, LC, 0);
    bus(1, TR, {28'h0, rd > 511 ? tm + 4'h1 : tm - 4'h1});
    // The trim port updates at the data-phase edge; look once it has settled.
    @(negedge clk);
    chk({28'h0, trim}, {28'h0, rd > 511 ? tm + 4'h1 : tm - 4'h1}, "trim step");
    run(32'h10);
    bus(1, CT, 0);
    bus(1, CT, 1);
    repeat (800) @(posedge clk);
    bus(1, CT, 0);
    rdc(ST, 0, "aborted");
    bus(0, RC, 0);
    v = rd;
    near(v, 800 / pp, 4, "ref partial");
    repeat (100) @(posedge clk);
    rdc(RC, v, "frozen");
    bus(0, LC, 0);
    v = rd;
    bus(1, CT, 2);
    rdc(RC, 0, "ref cleared");
    rdc(LC, v, "lp kept");
    bus(1, CT, 4);
    rdc(LC, 0, "lp cleared");
    bus(1, CT, 1);
    repeat (400) @(posedge clk);
    bus(1, CT, 9);
    rdc(ST, 2, "cal reset");
    rdc(RC, 0, "cal reset ref");
    rdc(LC, 0, "cal reset lp");
    $display("abort test done");
    end_sim();
  end
endmodule
`default_nettype wire
